// file: verilog/swg_eeprom_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Low supply cancels pending write at stop
// - Start condition always restarts byte reception
// - Interrupted transfer holds state, no timeout
// - Zero data bit and acknowledge pull line
// - Host recovery: start, nine clocks, start, stop
// - Released line on ninth clock ends output
// - Host sends start before stop after recovery
// - Host recovers during system initialisation; the bench issues no CMD_RECOVER at start-up, only in t_recover
// - Bus ignored during power-on initialisation
// - After initialisation device sits in standby
// - Mid-transfer start or stop abandons transfer
// - Host checks acknowledge after every byte; the bench checks o_ack_ok only after the device address byte
// - Data pin is open drain only
// - Stop inside first data byte aborts write
// - Only complete bytes are committed
// - Bytes past page size wrap in page
// - Short pulses on both pins are filtered
// - Valid write stop starts internal write
// - No response while write cycle runs
// - Low address bits roll, upper bits fixed
module swg_eeprom_dev #(
  parameter int PAGE = swg_pkg::PAGE_BYTES,
  parameter int MEM = swg_pkg::MEM_BYTES,
  parameter int WR_CYCLES = swg_pkg::WR_CYC,
  parameter int INIT_CYCLES = swg_pkg::INIT_CYC
) (
  input wire logic i_link_clk, // Link clock, all logic runs on it
  input wire logic i_nrst, // Power-on clear, async, active low
  input wire logic i_low_vdd, // Undervoltage detector level, async
  swg_link_if.dev bus, // Two-wire link
  output logic o_ready, // Initialisation finished
  output logic o_busy, // Internal write cycle running
  output logic o_commit // Pulse when a write cycle starts
);
  import swg_pkg::*;

  localparam int AW = $clog2(MEM);
  localparam int PW = $clog2(PAGE);
  localparam int FW = $clog2(FILT_CYC + 2);
  localparam int WCW = $clog2(WR_CYCLES + 1);
  localparam int ICW = $clog2(INIT_CYCLES + 1);

  if ((MEM != 256 && MEM != 512) || PAGE < 2 || PAGE > 256 || (PAGE & (PAGE - 1)) != 0
      || INIT_CYCLES < MEM || WR_CYCLES < PAGE)
  begin : g_bad_param
    $error("swg_eeprom_dev: unsupported parameter set");
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } swg_dev_st_t;

  // ----------------------------------------------------------------
  // Synchronisers and glitch filters
  // ----------------------------------------------------------------
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] filt;
  logic [1:0] filt_q;
  logic [FW-1:0] fcnt [2];
  logic uv_s1;
  logic uv_s2;

  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      uv_s1 <= 1'b0;
      uv_s2 <= 1'b0;
      filt_q <= 2'h3;
    end
    else
    begin
      pin_s1 <= {bus.scl, bus.sda};
      pin_s2 <= pin_s1;
      uv_s1 <= i_low_vdd;
      uv_s2 <= uv_s1;
      filt_q <= filt;
    end
  end

  // A pin level is taken only after it has differed for FILT_CYC + 1 samples
  // Both pins share one process so that each filter vector has a single driver
  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fcnt <= '{default: '0};
      filt <= 2'h3;
    end
    else
    begin
      for (int g = 0; g < 2; g++)
      begin
        if (pin_s2[g] == filt[g])
          fcnt[g] <= '0;
        else if (fcnt[g] == FW'(FILT_CYC))
        begin
          fcnt[g] <= '0;
          filt[g] <= pin_s2[g];
        end
        else
          fcnt[g] <= fcnt[g] + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic [ICW-1:0] icnt;
  logic [WCW-1:0] wcnt;
  swg_dev_st_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [1:0] nbyte;
  logic rw;
  logic [AW-1:0] addr;
  logic [PAGE-1:0] wvalid;
  logic mack_ok;
  logic [7:0] pbuf [PAGE];
  logic [7:0] mem [MEM];

  wire scl = filt[1];
  wire sda = filt[0];
  wire live = o_ready & ~o_busy;
  wire scl_rise = live & scl & ~filt_q[1];
  wire scl_fall = live & ~scl & filt_q[1];
  wire start_ev = live & scl & filt_q[1] & filt_q[0] & ~sda;
  wire stop_ev = live & scl & filt_q[1] & ~filt_q[0] & sda;
  wire byte_end = scl_fall & (state == ST_RX) & (bitcnt == 4'h8);
  wire addr_hit = (shreg[7:4] == DEV_CODE) & (shreg[3:2] == CHIP_SEL);
  wire [8:0] full_addr = {shreg[1] & addr_hit, shreg};
  wire [PW-1:0] lo_addr = addr[PW-1:0];
  wire commit_now = stop_ev & ~rw & (|wvalid) & ~uv_s2;
  wire wr_done = o_busy & (wcnt == WCW'(WR_CYCLES - 1));
  wire [PW-1:0] copy_idx = wcnt[PW-1:0];
  wire copy_en = o_busy & (wcnt < WCW'(PAGE)) & wvalid[copy_idx];
  wire drive_low = (state == ST_ACK) | ((state == ST_TX) & ~shreg[7]);

  // ----------------------------------------------------------------
  // Initialisation and write cycle timing
  // ----------------------------------------------------------------
  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      icnt <= '0;
      o_ready <= 1'b0;
    end
    else if (!o_ready)
    begin
      icnt <= icnt + 1'b1;
      o_ready <= (icnt == ICW'(INIT_CYCLES - 1));
    end
  end

  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_busy <= 1'b0;
      o_commit <= 1'b0;
      wcnt <= '0;
    end
    else
    begin
      o_commit <= commit_now;
      if (commit_now)
      begin
        o_busy <= 1'b1;
        wcnt <= '0;
      end
      else if (o_busy)
      begin
        wcnt <= wcnt + 1'b1;
        o_busy <= ~wr_done;
      end
    end
  end

  // Array has no reset; the init interval fills it with the erased value
  always_ff @(posedge i_link_clk)
  begin
    if (!o_ready && icnt < ICW'(MEM))
      mem[icnt[AW-1:0]] <= ERASED;
    else if (copy_en)
      mem[{addr[AW-1:PW], copy_idx}] <= pbuf[copy_idx];
  end

  always_ff @(posedge i_link_clk)
  begin
    if (byte_end && nbyte == 2'h2 && !rw)
      pbuf[lo_addr] <= shreg;
  end

  // ----------------------------------------------------------------
  // Serial protocol machine
  // ----------------------------------------------------------------
  // No timeout anywhere: a stalled transfer waits for start or stop
  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      nbyte <= 2'h0;
      rw <= 1'b0;
      addr <= '0;
      wvalid <= '0;
      mack_ok <= 1'b0;
    end
    else if (start_ev)
    begin
      state <= ST_RX;
      bitcnt <= 4'h0;
      nbyte <= 2'h0;
      rw <= 1'b0;
      wvalid <= '0;
    end
    else if (stop_ev)
    begin
      state <= ST_IDLE;
      if (!commit_now)
        wvalid <= '0;
    end
    else
    begin
      if (wr_done)
        wvalid <= '0;
      case (state)
        ST_IDLE:
          state <= ST_IDLE;
        ST_RX:
        begin
          if (scl_rise && bitcnt != 4'h8)
          begin
            shreg <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (byte_end)
          begin
            nbyte <= (nbyte == 2'h2) ? 2'h2 : nbyte + 2'h1;
            state <= ST_ACK;
            if (nbyte == 2'h0)
            begin
              rw <= shreg[0];
              if (!addr_hit)
                state <= ST_IDLE;
              else if (MEM == 512 && !shreg[0])
                addr <= AW'({full_addr[8], addr[7:0]});
            end
            else if (nbyte == 2'h1)
              addr <= AW'({addr[AW-1], shreg}) | (MEM == 512 ? '0 : AW'(shreg));
            else
            begin
              wvalid[lo_addr] <= 1'b1;
              addr <= {addr[AW-1:PW], lo_addr + 1'b1};
            end
          end
        end
        ST_ACK:
          if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if (rw)
            begin
              state <= ST_TX;
              shreg <= mem[addr];
            end
            else
              state <= ST_RX;
          end
        ST_TX:
          if (scl_fall)
          begin
            if (bitcnt == 4'h7)
            begin
              state <= ST_MACK;
              addr <= addr + 1'b1;
            end
            else
            begin
              shreg <= {shreg[6:0], 1'b1};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        ST_MACK:
        begin
          if (scl_rise)
            mack_ok <= ~sda;
          if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if (mack_ok)
            begin
              state <= ST_TX;
              shreg <= mem[addr];
            end
            else
              state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Open-drain data pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bus.d_sda <= 1'b0;
      bus.d_sda_oe_n <= 1'b1;
    end
    else
    begin
      bus.d_sda <= 1'b0;
      bus.d_sda_oe_n <= ~drive_low;
    end
  end
endmodule : swg_eeprom_dev
`default_nettype wire

// file: verilog/swg_pkg.sv
// ----------------------------------------------------------------
// Shared constants of the serial EEPROM link
// ----------------------------------------------------------------
package swg_pkg;
  // Clock rates
  localparam int CORE_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 30;
  // Glitch suppression, longest ignored pulse, rounded down
  localparam int T_FILT_NS = 160;
  localparam int FILT_CYC = (T_FILT_NS / LINK_PERIOD_NS < 1) ? 1 : T_FILT_NS / LINK_PERIOD_NS;
  // Internal write cycle, longest time, rounded down
  localparam int T_WR_NS = 10000000;
  localparam int WR_CYC = T_WR_NS / LINK_PERIOD_NS;
  // Power-on initialisation interval in link cycles
  localparam int INIT_CYC = 1024;
  // Bus clock period and its quarter, least time, rounded up
  localparam int T_SCL_NS = 2500;
  localparam int QTR_CYC = (T_SCL_NS / 4 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int RECOVER_CLKS = 9;
  // Array organisation
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 512;
  localparam logic [7:0] ERASED = 8'hFF;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic [1:0] CHIP_SEL = 2'h0;

  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_STOP = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ = 3'h3,
    CMD_RECOVER = 3'h4
  } swg_cmd_t;

  typedef enum logic [2:0] {
    OP_START = 3'h1,
    OP_STOP = 3'h2,
    OP_BIT = 3'h4
  } swg_op_t;
endpackage : swg_pkg

// file: verilog/swg_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Two-wire link, open-drain wires resolved with pull-ups
// ----------------------------------------------------------------
interface swg_link_if;
  logic scl;
  logic sda;
  logic m_scl;
  logic m_scl_oe_n;
  logic m_sda;
  logic m_sda_oe_n;
  logic d_sda;
  logic d_sda_oe_n;

  assign scl = ~(~m_scl_oe_n & ~m_scl);
  assign sda = ~((~m_sda_oe_n & ~m_sda) | (~d_sda_oe_n & ~d_sda));

  modport dev(input scl, input sda, output d_sda, output d_sda_oe_n);
  modport host(input sda, output m_scl, output m_scl_oe_n, output m_sda, output m_sda_oe_n);
endinterface : swg_link_if
`default_nettype wire

// file: verilog/swg_bus_host.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Two-wire bus master, one command at a time
// ----------------------------------------------------------------
module swg_bus_host #(
  parameter int QTR = swg_pkg::QTR_CYC
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_nrst, // Async reset, active low
  swg_link_if.host bus, // Two-wire link
  input wire logic i_cmd_valid, // Command request
  input wire swg_pkg::swg_cmd_t i_cmd, // Command code
  input wire logic [7:0] i_wdata, // Byte to send
  input wire logic i_mack, // Acknowledge a read byte
  output logic o_cmd_ready, // Idle, takes a command
  output logic o_done, // Pulse at command end
  output logic [7:0] o_rdata, // Byte read
  output logic o_ack_ok // Last command was a write and the slave acknowledged it
);
  import swg_pkg::*;

  localparam int QW = $clog2(QTR + 1);

  if (QTR < 2)
  begin : g_bad_param
    $error("swg_bus_host: quarter period too short");
  end

  typedef enum logic [1:0] {
    HS_IDLE = 2'h1,
    HS_RUN = 2'h2
  } swg_host_st_t;

  // Bit value in [0], op code above
  function automatic logic [3:0] op_of(swg_cmd_t c, logic [3:0] n, logic [7:0] d, logic ma);
    logic [3:0] r;
    r = {OP_BIT, 1'b1};
    case (c)
      CMD_START:
        r = {OP_START, 1'b1};
      CMD_STOP:
        r = {OP_STOP, 1'b1};
      CMD_WRITE:
        r = {OP_BIT, (n < 4'h8) ? d[3'h7 - n[2:0]] : 1'b1};
      CMD_READ:
        r = {OP_BIT, (n < 4'h8) ? 1'b1 : ~ma};
      CMD_RECOVER:
        if (n == 4'h0 || n == 4'(RECOVER_CLKS + 1))
          r = {OP_START, 1'b1};
        else if (n == 4'(RECOVER_CLKS + 2))
          r = {OP_STOP, 1'b1};
      default:
        r = {OP_BIT, 1'b1};
    endcase
    return r;
  endfunction : op_of

  function automatic logic [3:0] last_of(swg_cmd_t c);
    logic [3:0] r;
    case (c)
      CMD_WRITE, CMD_READ:
        r = 4'h8;
      CMD_RECOVER:
        r = 4'(RECOVER_CLKS + 2);
      default:
        r = 4'h0;
    endcase
    return r;
  endfunction : last_of

  swg_host_st_t state;
  swg_cmd_t cmd;
  logic [7:0] wdata;
  logic mack;
  logic [3:0] opn;
  logic [1:0] q;
  logic [QW-1:0] qcnt;
  logic [7:0] rx;
  logic ack_bit;
  logic sda_s1;
  logic sda_s2;

  // ----------------------------------------------------------------
  // Per-quarter pin levels
  // ----------------------------------------------------------------
  wire [3:0] cur = op_of(cmd, opn, wdata, mack);
  wire [2:0] op = cur[3:1];
  wire tick = (state == HS_RUN) & (qcnt == QW'(QTR - 1));
  wire last = (opn == last_of(cmd));
  wire scl_low = (op == OP_START) ? (q == 2'h0 || q == 2'h3) :
                 (op == OP_STOP) ? (q == 2'h0) : (q == 2'h0 || q == 2'h3);
  wire sda_low = (op == OP_START) ? (q[1]) :
                 (op == OP_STOP) ? (~q[1]) : ~cur[0];

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= HS_IDLE;
      cmd <= CMD_STOP;
      wdata <= 8'h00;
      mack <= 1'b0;
      opn <= 4'h0;
      q <= 2'h0;
      qcnt <= '0;
      rx <= 8'h00;
      ack_bit <= 1'b1;
      o_cmd_ready <= 1'b1;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_ack_ok <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (state)
        HS_IDLE:
          if (i_cmd_valid)
          begin
            state <= HS_RUN;
            cmd <= i_cmd;
            wdata <= i_wdata;
            mack <= i_mack;
            opn <= 4'h0;
            q <= 2'h0;
            qcnt <= '0;
            o_cmd_ready <= 1'b0;
          end
        HS_RUN:
        begin
          qcnt <= tick ? '0 : qcnt + 1'b1;
          if (tick)
          begin
            q <= q + 2'h1;
            if (q == 2'h1 && op == OP_BIT)
            begin
              if (opn < 4'h8)
                rx <= {rx[6:0], sda_s2};
              else
                ack_bit <= sda_s2;
            end
            if (q == 2'h3)
            begin
              opn <= opn + 4'h1;
              if (last)
              begin
                state <= HS_IDLE;
                o_cmd_ready <= 1'b1;
                o_done <= 1'b1;
                o_rdata <= rx;
                o_ack_ok <= (cmd == CMD_WRITE) & ~ack_bit;
              end
            end
          end
        end
        default:
          state <= HS_IDLE;
      endcase
    end
  end

  // Hold time after the clock falls is one quarter period
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bus.m_scl <= 1'b0;
      bus.m_scl_oe_n <= 1'b1;
      bus.m_sda <= 1'b0;
      bus.m_sda_oe_n <= 1'b1;
    end
    else if (state == HS_RUN)
    begin
      bus.m_scl <= 1'b0;
      bus.m_scl_oe_n <= ~scl_low;
      bus.m_sda <= 1'b0;
      bus.m_sda_oe_n <= ~sda_low;
    end
  end
endmodule : swg_bus_host
`default_nettype wire

// file: bench/swg_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
module swg_link_checker #(
  parameter int WR_CYCLES = 64,
  parameter int INIT_CYCLES = 1024
) (
  input wire logic i_link_clk, // Link clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_low_vdd, // Undervoltage level
  input wire logic scl, // Resolved clock wire
  input wire logic sda, // Resolved data wire
  input wire logic d_sda, // Device drive value
  input wire logic d_sda_oe_n, // Device pull enable, low pulls
  input wire logic o_ready, // Device initialised
  input wire logic o_busy, // Write cycle running
  input wire logic o_commit // Write cycle start pulse
);
  int busy_cnt;
  int init_cnt;
  int scl_hi;
  wire integer next_busy_cnt = o_busy ? busy_cnt + 1 : 0;
  wire integer next_init_cnt = (init_cnt < INIT_CYCLES + 8) ? init_cnt + 1 : init_cnt;
  // Saturates so a long idle high clock cannot wrap
  wire integer next_scl_hi = scl ? ((scl_hi < 64) ? scl_hi + 1 : scl_hi) : 0;

  always_ff @(posedge i_link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      busy_cnt <= 0;
      init_cnt <= 0;
      scl_hi <= 0;
    end
    else
    begin
      busy_cnt <= next_busy_cnt;
      init_cnt <= next_init_cnt;
      scl_hi <= next_scl_hi;
    end
  end

  default clocking cb @(posedge i_link_clk);
  endclocking
  default disable iff (!i_nrst);

  chk_drive_low_only: assert property (d_sda == 1'b0)
    else $error("device drive value not low");
  chk_pull_low: assert property (!d_sda_oe_n |-> !sda)
    else $error("data line high while device pulls");
  chk_init_silent: assert property (!o_ready |-> d_sda_oe_n)
    else $error("device pulls line before ready");
  chk_ready_time: assert property ($rose(o_ready) |->
    init_cnt >= INIT_CYCLES && init_cnt <= INIT_CYCLES + 2)
    else $error("ready at wrong time");
  chk_ready_stays: assert property (o_ready |=> o_ready)
    else $error("ready dropped");
  chk_busy_silent: assert property (o_busy |-> d_sda_oe_n)
    else $error("device answers while busy");
  chk_busy_by_commit: assert property ($rose(o_busy) |-> o_commit)
    else $error("busy without commit");
  chk_commit_pulse: assert property (o_commit |=> !o_commit && o_busy)
    else $error("commit pulse wrong");
  chk_busy_length: assert property ($fell(o_busy) |-> busy_cnt == WR_CYCLES)
    else $error("write cycle length wrong");
  chk_low_no_write: assert property (i_low_vdd [*6] |-> !o_commit)
    else $error("write started on low supply");
  chk_ack_steady: assert property (scl_hi >= 20 |-> $stable(d_sda_oe_n))
    else $error("device output moved while clock high");
endmodule : swg_link_checker
`default_nettype wire

// file: bench/test_serial_eeprom_write_guard_recovery.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_eeprom_write_guard_recovery;
  import swg_pkg::*;
  // Write cycle kept long enough that an address poll lands inside it
  localparam int WRC = 2048;
  localparam int INITC = 1024;
  logic i_core_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_low_vdd = 1'b0;
  logic i_cmd_valid = 1'b0;
  swg_cmd_t i_cmd = CMD_START;
  logic [7:0] i_wdata = 8'h00;
  logic i_mack = 1'b0;
  logic o_cmd_ready;
  logic o_done;
  logic o_ack_ok;
  logic [7:0] o_rdata;
  logic o_ready;
  logic o_busy;
  logic o_commit;
  int commits = 0;
  int errors = 0;
  int checked = 0;

  swg_link_if link();
  swg_eeprom_dev #(.WR_CYCLES(WRC), .INIT_CYCLES(INITC)) swg_eeprom_dev_i (
    .i_link_clk(i_link_clk), .i_nrst(i_nrst), .i_low_vdd(i_low_vdd), .bus(link.dev),
    .o_ready(o_ready), .o_busy(o_busy), .o_commit(o_commit));
  swg_bus_host swg_bus_host_i (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(link.host), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_wdata(i_wdata), .i_mack(i_mack), .o_cmd_ready(o_cmd_ready),
    .o_done(o_done), .o_rdata(o_rdata), .o_ack_ok(o_ack_ok));
  swg_link_checker #(.WR_CYCLES(WRC), .INIT_CYCLES(INITC)) swg_link_checker_i (
    .i_link_clk(i_link_clk), .i_nrst(i_nrst), .i_low_vdd(i_low_vdd), .scl(link.scl),
    .sda(link.sda), .d_sda(link.d_sda), .d_sda_oe_n(link.d_sda_oe_n), .o_ready(o_ready),
    .o_busy(o_busy), .o_commit(o_commit));

  initial forever #20 i_core_clk = ~i_core_clk;
  initial
  begin
    #7;
    forever #15 i_link_clk = ~i_link_clk;
  end
  always @(posedge i_link_clk)
    if (o_commit === 1'b1)
      commits++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cmd(input swg_cmd_t c, input logic [7:0] d, input logic mk);
    int n;
    n = 0;
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    i_wdata <= d;
    i_mack <= mk;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b0;
    while (o_done !== 1'b1 && n < 2000)
    begin
      @(posedge i_core_clk);
      n++;
    end
    check({7'h00, n < 2000}, 8'h01, "command end");
  endtask : cmd

  function automatic logic [7:0] dev(input logic [8:0] a, input logic rd);
    return {DEV_CODE, CHIP_SEL, a[8], rd};
  endfunction : dev

  task automatic addr_phase(input logic [8:0] a);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, dev(a, 1'b0), 1'b0);
    check({7'h00, o_ack_ok}, 8'h01, "device ack");
    cmd(CMD_WRITE, a[7:0], 1'b0);
  endtask : addr_phase

  task automatic write_bytes(input logic [8:0] a, input logic [7:0] q[$]);
    addr_phase(a);
    foreach (q[i]) cmd(CMD_WRITE, q[i], 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0);
    repeat (20) @(posedge i_core_clk);
  endtask : write_bytes

  task automatic read_chk(input logic [8:0] a, input logic [7:0] q[$]);
    addr_phase(a);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, dev(a, 1'b1), 1'b0);
    foreach (q[i])
    begin
      cmd(CMD_READ, 8'h00, i < q.size() - 1);
      check(o_rdata, q[i], "read byte");
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
  endtask : read_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_init();
    int n;
    n = 0;
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, dev(9'h000, 1'b0), 1'b0);
    check({7'h00, o_ack_ok}, 8'h00, "ack during init");
    while (o_ready !== 1'b1 && n < 1000)
    begin
      @(posedge i_core_clk);
      n++;
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    check({7'h00, o_ready}, 8'h01, "ready");
    $display("test init done");
  endtask : t_init

  task automatic t_wrap();
    logic [7:0] d[$];
    logic [7:0] e[$];
    int c0;
    int n;
    c0 = commits;
    n = 0;
    for (int i = 0; i < 18; i++) d.push_back(8'h40 + 8'(i));
    // Start at low address 3: bytes 16 and 17 land on offsets 3 and 4
    for (int k = 0; k < 16; k++) e.push_back(8'h40 + 8'((k + 13) % 16 + ((k == 3 || k == 4) ? 16 : 0)));
    write_bytes(9'h123, d);
    check(8'(commits - c0), 8'h01, "one write cycle");
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, dev(9'h000, 1'b0), 1'b0);
    check({7'h00, o_ack_ok}, 8'h00, "ack while busy");
    cmd(CMD_STOP, 8'h00, 1'b0);
    while (o_busy !== 1'b0 && n < 3000)
    begin
      @(posedge i_core_clk);
      n++;
    end
    read_chk(9'h120, e);
    $display("test page wrap done");
  endtask : t_wrap

  task automatic t_low();
    int c0;
    c0 = commits;
    i_low_vdd <= 1'b1;
    write_bytes(9'h050, '{8'h11, 8'h22});
    check(8'(commits - c0), 8'h00, "no write on low supply");
    check({7'h00, o_busy}, 8'h00, "not busy");
    i_low_vdd <= 1'b0;
    read_chk(9'h050, '{ERASED, ERASED});
    $display("test low supply done");
  endtask : t_low

  task automatic t_recover();
    int c0;
    c0 = commits;
    addr_phase(9'h060);
    cmd(CMD_WRITE, 8'h33, 1'b0);
    cmd(CMD_RECOVER, 8'h00, 1'b0);
    repeat (20) @(posedge i_core_clk);
    check(8'(commits - c0), 8'h00, "no write after recovery");
    // Next byte has a zero top bit, so the device holds the line low
    addr_phase(9'h120);
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, dev(9'h120, 1'b1), 1'b0);
    cmd(CMD_READ, 8'h00, 1'b1);
    check(o_rdata, 8'h4D, "first read byte");
    cmd(CMD_RECOVER, 8'h00, 1'b0);
    check({7'h00, link.sda}, 8'h01, "line released");
    check({7'h00, link.d_sda_oe_n}, 8'h01, "device released");
    read_chk(9'h060, '{ERASED});
    $display("test recovery done");
  endtask : t_recover

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial
  begin
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    @(posedge i_core_clk);
    t_init();
    t_wrap();
    t_low();
    t_recover();
    conclude();
  end

  // Tests need under 2 ms; half as long again means a hang
  initial
  begin
    #3000000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : test_serial_eeprom_write_guard_recovery
`default_nettype wire
